//--- verilog/acf_pkg.sv
// package: register map, field layout and reset values of the afc and channel filter config
package acf_pkg;
  localparam int unsigned ACF_ADDR_W = 12;
  localparam int unsigned ACF_REG_W = 8;
  localparam int unsigned ACF_NUM_REGS = 2;
  localparam int unsigned ACF_NUM_DIV_CODES = 8;
  localparam logic [3:0] ACF_DIV_OFFSET = 4'h1;
  // printed offsets are not all multiples of four, so they are indices
  localparam logic [7:0] ACF_IDX_FREQ_CTRL = 8'h0f;
  localparam logic [7:0] ACF_IDX_CHAN_FILT = 8'h10;
  localparam logic [11:0] ACF_ADDR_FREQ_CTRL = {2'h0, ACF_IDX_FREQ_CTRL, 2'h0};
  localparam logic [11:0] ACF_ADDR_CHAN_FILT = {2'h0, ACF_IDX_CHAN_FILT, 2'h0};
  localparam logic [7:0] ACF_RST_FREQ_CTRL = 8'hac;
  localparam logic [7:0] ACF_RST_CHAN_FILT = 8'h00;
  localparam logic [7:0] ACF_CHAN_FILT_WMASK = 8'he7;
  localparam logic [1:0] ACF_SETTLE_OFF = 2'h0;
  localparam logic [1:0] ACF_SETTLE_FAST = 2'h1;
  localparam logic [1:0] ACF_SETTLE_MEDIUM = 2'h2;
  localparam logic [1:0] ACF_SETTLE_SLOW = 2'h3;
  localparam logic [2:0] ACF_PAIRS_1 = 3'h1;
  localparam logic [2:0] ACF_PAIRS_2 = 3'h2;
  localparam logic [2:0] ACF_PAIRS_4 = 3'h4;
  localparam logic [1:0] ACF_DEV_EXP_BIAS = 2'h3;
  localparam logic [3:0] ACF_DEV_DIVISOR = 4'h3;
  // base channel bandwidth in units of 100 Hz (307.2 kHz)
  localparam logic [11:0] ACF_BW_BASE = 12'hc00;

  typedef struct packed {
    logic [1:0] settling;
    logic [1:0] rx_deviation_exponent;
    logic [3:0] rx_deviation_mantissa;
  } acf_freq_ctrl_type;

  typedef struct packed {
    logic filter_bypass;
    logic [1:0] decimator_input_shift;
    logic [1:0] reserved;
    logic [2:0] decimation_divisor_code;
  } acf_chan_filt_type;

  typedef struct packed {
    logic afc_enable;
    logic [2:0] afc_avg_pairs;
    logic [1:0] dev_shift_up;
    logic [1:0] dev_shift_down;
    logic [3:0] dev_mantissa;
    logic [3:0] dev_divisor;
    logic filter_bypass;
    logic [1:0] decimator_input_shift;
    logic [3:0] decimation_divisor;
    logic [11:0] chan_bw;
  } acf_modem_cfg_type;
endpackage : acf_pkg

//--- verilog/acf_config_regs.sv
// afc and channel filter configuration registers with apb slave
`timescale 1ns/1ns
module acf_config_regs #(
  // address decode constants are fixed at this width
  parameter int unsigned ADDR_W = acf_pkg::ACF_ADDR_W,
  // bus data width; configuration bytes sit in the low lane
  parameter int unsigned DATA_W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [DATA_W/8-1:0] i_pstrb,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output acf_pkg::acf_modem_cfg_type o_modem_cfg
);
  import acf_pkg::*;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // offsets are compared at the package width, no other width is served
  if (ADDR_W != ACF_ADDR_W) begin : g_bad_addr_w
    $error("acf_config_regs: ADDR_W must equal the package address width");
  end

  // each register is one byte in lane zero of a word of whole bytes
  if ((DATA_W < ACF_REG_W) || ((DATA_W % ACF_REG_W) != 0)) begin : g_bad_data_w
    $error("acf_config_regs: DATA_W must be a whole number of bytes");
  end

  // the read path ors the lanes, which needs distinct offsets
  if (ACF_ADDR_FREQ_CTRL == ACF_ADDR_CHAN_FILT) begin : g_bad_map
    $error("acf_config_regs: register offsets must differ");
  end

  // reserved filter bits are never stored, so they must reset to zero
  if ((ACF_RST_CHAN_FILT & ~ACF_CHAN_FILT_WMASK) != 8'h00) begin : g_bad_rst
    $error("acf_config_regs: reserved filter bits must reset to zero");
  end

  // ------------------------------------------------------------
  // apb access
  // ------------------------------------------------------------
  acf_freq_ctrl_type freq_ctrl_r;
  acf_chan_filt_type chan_filt_r;
  logic setup;
  logic hit_fc;
  logic hit_cf;
  logic [ACF_REG_W-1:0] rd_nxt;
  logic [ACF_NUM_REGS-1:0][ADDR_W-1:0] reg_addr;
  logic [ACF_NUM_REGS-1:0][ACF_REG_W-1:0] reg_view;
  logic [ACF_NUM_REGS-1:0][ACF_REG_W-1:0] rd_lane;
  logic [ACF_NUM_REGS-1:0] hit_v;

  // zero wait state: pready is raised for the access cycle only
  assign setup = i_psel && !i_penable;

  // one decode slice per register; the index order fixes the map
  assign reg_addr[0] = ADDR_W'(ACF_ADDR_FREQ_CTRL);
  assign reg_addr[1] = ADDR_W'(ACF_ADDR_CHAN_FILT);
  assign reg_view[0] = freq_ctrl_r;
  assign reg_view[1] = chan_filt_r & ACF_CHAN_FILT_WMASK;

  for (genvar g = 0; g < ACF_NUM_REGS; g++) begin : g_reg_dec
    assign hit_v[g] = (i_paddr == reg_addr[g]);
    assign rd_lane[g] = hit_v[g] ? reg_view[g] : '0;
  end

  assign hit_fc = hit_v[0];
  assign hit_cf = hit_v[1];

  // offsets are distinct, so at most one lane is set and an or is a mux
  always_comb begin
    rd_nxt = '0;
    for (int i = 0; i < ACF_NUM_REGS; i++) begin
      rd_nxt = rd_nxt | rd_lane[i];
    end
  end

  // ------------------------------------------------------------
  // bus response
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= setup;
    end
  end

  // unmapped offsets answer with an error and never touch a register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= setup && !(|hit_v);
    end
  end

  // read data is zero outside a read answer so stale bytes never leak
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= '0;
    end else begin
      o_prdata <= (setup && !i_pwrite) ? DATA_W'(rd_nxt) : '0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // writes land one cycle after setup, at the access edge
  logic wr_acc;
  assign wr_acc = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0];

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      freq_ctrl_r <= ACF_RST_FREQ_CTRL;
    end else if (wr_acc && hit_fc) begin
      freq_ctrl_r <= i_pwdata[ACF_REG_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      chan_filt_r <= ACF_RST_CHAN_FILT;
    end else if (wr_acc && hit_cf) begin
      chan_filt_r <= i_pwdata[ACF_REG_W-1:0] & ACF_CHAN_FILT_WMASK;
    end
  end

  // ------------------------------------------------------------
  // decoded modem configuration
  // ------------------------------------------------------------
  acf_modem_cfg_type cfg_nxt;
  logic [3:0] div_w;
  logic afc_enable_nxt;
  logic [2:0] afc_pairs_nxt;
  logic [ACF_NUM_DIV_CODES-1:0][11:0] bw_table;

  assign afc_enable_nxt = (freq_ctrl_r.settling != ACF_SETTLE_OFF);

  always_comb begin
    case (freq_ctrl_r.settling)
      ACF_SETTLE_FAST: afc_pairs_nxt = ACF_PAIRS_1;
      ACF_SETTLE_MEDIUM: afc_pairs_nxt = ACF_PAIRS_2;
      ACF_SETTLE_SLOW: afc_pairs_nxt = ACF_PAIRS_4;
      // code zero: no averaging, the demodulator sees a zero offset
      default: afc_pairs_nxt = '0;
    endcase
  end

  // ------------------------------------------------------------
  // bandwidth table
  // ------------------------------------------------------------
  // one constant per code: a table is cheaper than a divider
  for (genvar c = 0; c < ACF_NUM_DIV_CODES; c++) begin : g_bw_table
    localparam int unsigned DIVISOR = c + ACF_DIV_OFFSET;
    assign bw_table[c] = 12'(ACF_BW_BASE / DIVISOR);
  end

  always_comb begin
    cfg_nxt = '0;
    cfg_nxt.afc_enable = afc_enable_nxt;
    cfg_nxt.afc_avg_pairs = afc_pairs_nxt;
    // deviation scale: mant << exp >> 3, then / 3 downstream
    cfg_nxt.dev_mantissa = freq_ctrl_r.rx_deviation_mantissa;
    cfg_nxt.dev_shift_up = freq_ctrl_r.rx_deviation_exponent;
    cfg_nxt.dev_shift_down = ACF_DEV_EXP_BIAS;
    cfg_nxt.dev_divisor = ACF_DEV_DIVISOR;
    cfg_nxt.filter_bypass = chan_filt_r.filter_bypass;
    cfg_nxt.decimator_input_shift = chan_filt_r.decimator_input_shift;
    cfg_nxt.decimation_divisor = div_w;
    // bandwidth in 100 hz units, truncated
    // code 7 gives 8 and 384
    cfg_nxt.chan_bw = bw_table[chan_filt_r.decimation_divisor_code];
  end

  assign div_w = {1'b0, chan_filt_r.decimation_divisor_code} + ACF_DIV_OFFSET;

  // registered so every output leaves a flip-flop
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_modem_cfg <= '0;
    end else begin
      o_modem_cfg <= cfg_nxt;
    end
  end
endmodule : acf_config_regs

//--- tb/acf_host_model.sv
// host model issuing apb transfers to the config block
`timescale 1ns/1ns
module acf_host_model (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata, o_pstrb} = '0;
  // released address and data lines show inverted values so stale data cannot pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v,
    input logic [3:0] s, output logic [31:0] rd, output logic er);
    @(posedge i_clk);
    {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata, o_pstrb} <= {2'h2, w, a, v, s};
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    rd = i_prdata;
    er = i_pslverr;
    {o_psel, o_penable, o_paddr, o_pwdata} <= {2'h0, ~a, ~v};
  endtask : xfer
endmodule : acf_host_model

//--- tb/acf_config_regs_monitor.sv
// port checker of the config block
`timescale 1ns/1ns
module acf_config_regs_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire acf_pkg::acf_modem_cfg_type o_modem_cfg
);
  import acf_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire acf_modem_cfg_type c = o_modem_cfg;
  wire logic a = i_psel && i_penable && o_pready;
  wire logic wf = a && i_pwrite && i_pstrb[0] && i_paddr == ACF_ADDR_FREQ_CTRL;
  wire logic wc = a && i_pwrite && i_pstrb[0] && i_paddr == ACF_ADDR_CHAN_FILT;
  wire logic um = i_paddr != ACF_ADDR_FREQ_CTRL && i_paddr != ACF_ADDR_CHAN_FILT;
  ready_setup_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no pready");
  afc_off_a: assert property (wf |-> ##2 c.afc_enable == ($past(i_pwdata[7:6], 2) != 0))
    else $error("afc enable");
  avg_pairs_a: assert property (wf && i_pwdata[7:6] != 0 |-> ##2
    c.afc_avg_pairs == 3'h1 << ($past(i_pwdata[7:6], 2) - 1)) else $error("pairs");
  dev_field_a: assert property (wf |-> ##2
    {c.dev_shift_up, c.dev_mantissa, c.dev_divisor} == {$past(i_pwdata[5:0], 2), 4'h3})
    else $error("deviation");
  bypass_shift_a: assert property (wc |-> ##2
    {c.filter_bypass, c.decimator_input_shift} == $past(i_pwdata[7:5], 2)) else $error("bypass");
  divisor_a: assert property (wc |-> ##2
    c.decimation_divisor == $past(i_pwdata[2:0], 2) + 1) else $error("divisor");
  bandwidth_a: assert property (c.decimation_divisor != 0 |->
    c.chan_bw == ACF_BW_BASE / c.decimation_divisor) else $error("bandwidth");
  unmapped_a: assert property (a && um |-> o_pslverr && o_prdata == 0) else $error("unmapped");
  cover property (wf);
  cover property (wc);
  cover property (a && um);
endmodule : acf_config_regs_monitor

//--- tb/tb.sv
// self-checking testbench of the config block
`timescale 1ns/1ns
module tb;
  import acf_pkg::*;
  logic i_clk_sys = 0, i_rst = 1, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, e;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd, d, fq;
  logic [3:0] i_pstrb;
  acf_modem_cfg_type o_modem_cfg;
  int miscompares = 0, total_checks = 0;
  acf_host_model host (.i_clk(i_clk_sys), .i_pready(o_pready), .i_prdata(o_prdata),
    .i_pslverr(o_pslverr), .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
    .o_paddr(i_paddr), .o_pwdata(i_pwdata), .o_pstrb(i_pstrb));
  acf_config_regs uut (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_modem_cfg);
  initial forever #5 i_clk_sys = ~i_clk_sys;
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask : chk
  function automatic logic [31:0] exp_pairs(input logic [1:0] s);
    return (s == 2'h0) ? 32'h0 : (32'h1 << (s - 2'h1));
  endfunction : exp_pairs
  function automatic logic [31:0] exp_bw(input logic [2:0] c);
    return 32'd3072 / ({29'h0, c} + 32'h1);
  endfunction : exp_bw
  task automatic test_done;
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(5));
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 0;
    repeat (2) @(posedge i_clk_sys);
    chk("pairs", 2, o_modem_cfg.afc_avg_pairs);
    host.xfer(0, ACF_ADDR_FREQ_CTRL, 0, 4'hf, rd, e);
    chk("freq", 8'hac, rd);
    for (int k = 0; k < 8; k++) begin
      // normalised mantissa; deviation drawn in the legal span
      fq = {24'h0, k[1:0], 2'($urandom), 1'b1, 3'($urandom)};
      host.xfer(1, ACF_ADDR_FREQ_CTRL, fq, 4'hf, rd, e);
      host.xfer(0, ACF_ADDR_FREQ_CTRL, 0, 4'hf, rd, e);
      chk("freq", fq, rd);
      chk("afc", k % 4 != 0, o_modem_cfg.afc_enable);
      chk("pairs", exp_pairs(k[1:0]), o_modem_cfg.afc_avg_pairs);
      chk("dev", fq[5:0], {o_modem_cfg.dev_shift_up, o_modem_cfg.dev_mantissa});
      chk("scale", 6'h33, {o_modem_cfg.dev_shift_down, o_modem_cfg.dev_divisor});
      // shift follows divisor; bypass and reserved bits are random
      d = {24'h0, 1'($urandom), 1'b0, k > 1, 2'($urandom), k[2:0]};
      host.xfer(1, ACF_ADDR_CHAN_FILT, d, 4'hf, rd, e);
      host.xfer(0, ACF_ADDR_CHAN_FILT, 0, 4'hf, rd, e);
      chk("filt", d & 32'he7, rd);
      chk("div", k + 1, o_modem_cfg.decimation_divisor);
      chk("bw", exp_bw(k[2:0]), o_modem_cfg.chan_bw);
      chk("byp", d[7:5], {o_modem_cfg.filter_bypass, o_modem_cfg.decimator_input_shift});
    end
    host.xfer(0, 12'h44, 0, 4'hf, rd, e);
    chk("err", 1, e);
    chk("rd", 0, rd);
    host.xfer(1, ACF_ADDR_FREQ_CTRL, 0, 4'h0, rd, e);
    host.xfer(0, ACF_ADDR_FREQ_CTRL, 0, 4'hf, rd, e);
    chk("strb", fq, rd);
    i_rst <= 1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 0;
    repeat (2) @(posedge i_clk_sys);
    chk("div", 1, o_modem_cfg.decimation_divisor);
    host.xfer(0, ACF_ADDR_FREQ_CTRL, 0, 4'hf, rd, e);
    chk("freq", 8'hac, rd);
    test_done();
  end
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
endmodule : tb
bind acf_config_regs acf_config_regs_monitor mon (.i_clk_sys, .i_rst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_modem_cfg);
